// file: tcu_capture.sv
`timescale 1ns/1ps

// What this block does
// - Capture copies full 16-bit timebase count.
// - Mode picks falling, rising, 4th, 16th.
// - Every capture sets the event flag.
// - Flag cleared only by software.
// - Newer capture overwrites unread result.
// - Pin level sampled whatever its direction.
// - Mode change may raise a spurious flag.
// - Prescaler cleared when off or not capturing.
// - Any reset clears the prescaler.
// - Prescaler switch keeps count; turn off first.
// - Sleep freezes instruction-clocked timebase.
// - Sleep keeps capture with external clock.

`include "tcu_cfg.svh"

module tcu_capture (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Register port.
   input tcu_pkg::tcu_bus_req_s bus,
   output logic [`TCU_DW-1:0] rdata,
   // Pins and power state.
   input wire logic capture_pin,
   input wire logic timebase_ext_clk,
   input wire logic sleep_mode,
   // Interrupt and timebase view.
   output logic irq,
   output logic [15:0] timebase_count
);
   import tcu_pkg::*;

   tcu_state_s st;
   tcu_state_s next_st;
   tcu_edge_s pin_edge;
   tcu_edge_s ext_edge;
   logic inst_tick;
   logic tb_tick;
   logic cap;
   logic wr_ctrl;
   logic wr_req;
   logic wr_tb;

   function automatic logic is_capture(input logic [3:0] mode);
      is_capture = (mode == `TCU_MODE_FALL) || (mode == `TCU_MODE_RISE) ||
         (mode == `TCU_MODE_RISE4) || (mode == `TCU_MODE_RISE16);
   endfunction

   function automatic logic [3:0] presc_last(input logic [3:0] mode);
      presc_last = (mode == `TCU_MODE_RISE16) ? `TCU_PRESC_16 :
         `TCU_PRESC_4;
   endfunction

   function automatic logic [`TCU_DW-1:0] read_mux(
      input tcu_state_s s,
      input logic [`TCU_AW-1:0] addr
   );
      read_mux = 8'h00;
      unique case (addr)
         `TCU_OFS_CTRL: read_mux = {4'h0, s.mode};
         `TCU_OFS_RES_LO: read_mux = s.result[7:0];
         `TCU_OFS_RES_HI: read_mux = s.result[15:8];
         `TCU_OFS_REQ: read_mux = {7'h00, s.flag};
         `TCU_OFS_ENA: read_mux = {7'h00, s.enable};
         `TCU_OFS_TB_CFG: read_mux = {6'h00, s.tb_ext, s.tb_run};
         `TCU_OFS_TB_LO: read_mux = s.tb_count[7:0];
         `TCU_OFS_TB_HI: read_mux = s.tb_count[15:8];
         default: read_mux = 8'h00;
      endcase
   endfunction

   tcu_edge_detect u_pin_edge (
      .core_clk(core_clk),
      .rstn(rstn),
      .level_in(capture_pin),
      .edge_out(pin_edge)
   );

   tcu_edge_detect u_ext_edge (
      .core_clk(core_clk),
      .rstn(rstn),
      .level_in(timebase_ext_clk),
      .edge_out(ext_edge)
   );

   assign wr_ctrl = bus.wr && (bus.addr == `TCU_OFS_CTRL);
   assign wr_req = bus.wr && (bus.addr == `TCU_OFS_REQ);
   assign wr_tb = bus.wr && ((bus.addr == `TCU_OFS_TB_LO) ||
      (bus.addr == `TCU_OFS_TB_HI));
   assign inst_tick = (st.div == `TCU_INST_LAST);

   assign tb_tick = st.tb_run &&
      (st.tb_ext ? ext_edge.rise : (inst_tick && !sleep_mode));

   always_comb begin
      cap = 1'b0;
      unique case (st.mode)
         `TCU_MODE_FALL: cap = pin_edge.fall;
         `TCU_MODE_RISE: cap = pin_edge.rise;
         `TCU_MODE_RISE4, `TCU_MODE_RISE16:
            cap = pin_edge.rise && (st.presc == presc_last(st.mode));
         default: cap = 1'b0;
      endcase
   end

   always_comb begin
      next_st = st;
      next_st.div = 2'(st.div + 2'h1);
      if (tb_tick) begin
         next_st.tb_count = 16'(st.tb_count + 16'h0001);
      end
      if (!is_capture(st.mode)) begin
         next_st.presc = `TCU_PRESC_RST;
      end else if ((st.mode == `TCU_MODE_RISE4 ||
                    st.mode == `TCU_MODE_RISE16) && pin_edge.rise) begin
         next_st.presc = cap ? `TCU_PRESC_RST : 4'(st.presc + 4'h1);
      end
      // Software writes.
      if (bus.wr) begin
         unique case (bus.addr)
            `TCU_OFS_CTRL:
               next_st.mode = bus.wdata[`TCU_MODE_MSB:`TCU_MODE_LSB];
            `TCU_OFS_RES_LO: next_st.result[7:0] = bus.wdata;
            `TCU_OFS_RES_HI: next_st.result[15:8] = bus.wdata;
            `TCU_OFS_REQ: begin
               if (bus.wdata[`TCU_FLAG_BIT]) begin
                  next_st.flag = 1'b0;
               end
            end
            `TCU_OFS_ENA: next_st.enable = bus.wdata[`TCU_ENA_BIT];
            `TCU_OFS_TB_CFG: begin
               next_st.tb_run = bus.wdata[`TCU_TB_RUN_BIT];
               next_st.tb_ext = bus.wdata[`TCU_TB_EXT_BIT];
            end
            `TCU_OFS_TB_LO: next_st.tb_count[7:0] = bus.wdata;
            `TCU_OFS_TB_HI: next_st.tb_count[15:8] = bus.wdata;
            default: next_st.mode = st.mode;
         endcase
      end
      if (cap) begin
         next_st.result = st.tb_count;
      end
      if (cap) begin
         next_st.flag = 1'b1;
      end
      next_st.rdata = bus.rd ? read_mux(st, bus.addr) : `TCU_RDATA_RST;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
         st.mode <= `TCU_CTRL_RST;
         st.result <= `TCU_RES_RST;
         st.tb_count <= `TCU_TB_RST;
         st.presc <= `TCU_PRESC_RST;
         st.rdata <= `TCU_RDATA_RST;
      end else begin
         st <= next_st;
      end
   end

   assign rdata = st.rdata;
   assign irq = st.flag & st.enable;
   assign timebase_count = st.tb_count;

   property p_capture_value;
      @(posedge core_clk) disable iff (!rstn)
      cap |=> (st.result == $past(st.tb_count));
   endproperty
   a_capture_value: assert property (p_capture_value)
      else $error("capture did not latch the timebase count");

   property p_fall_event;
      @(posedge core_clk) disable iff (!rstn)
      (st.mode == `TCU_MODE_FALL) && pin_edge.fall |-> cap;
   endproperty
   a_fall_event: assert property (p_fall_event)
      else $error("falling edge not captured in falling mode");

   property p_fourth_edge;
      @(posedge core_clk) disable iff (!rstn)
      (st.mode == `TCU_MODE_RISE4) && pin_edge.rise &&
         (st.presc != `TCU_PRESC_4) |=> !$past(cap) && (st.presc ==
         4'($past(st.presc) + 4'h1));
   endproperty
   a_fourth_edge: assert property (p_fourth_edge)
      else $error("every fourth edge count went wrong");

   property p_flag_set;
      @(posedge core_clk) disable iff (!rstn)
      cap |=> st.flag ##0 irq == st.enable;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("capture did not set the event flag");

   property p_flag_sticky;
      @(posedge core_clk) disable iff (!rstn)
      st.flag && !(wr_req && bus.wdata[`TCU_FLAG_BIT]) |=> st.flag;
   endproperty
   a_flag_sticky: assert property (p_flag_sticky)
      else $error("event flag cleared without a software write");

   property p_overwrite;
      @(posedge core_clk) disable iff (!rstn)
      cap && st.flag |=> (st.result == $past(st.tb_count));
   endproperty
   a_overwrite: assert property (p_overwrite)
      else $error("second capture did not overwrite the result");

   property p_presc_off;
      @(posedge core_clk) disable iff (!rstn)
      !is_capture(st.mode) |=> (st.presc == `TCU_PRESC_RST);
   endproperty
   a_presc_off: assert property (p_presc_off)
      else $error("prescaler not cleared while unit is off");

   property p_presc_keep;
      @(posedge core_clk) disable iff (!rstn)
      (st.mode == `TCU_MODE_RISE4) && wr_ctrl &&
         (bus.wdata[3:0] == `TCU_MODE_RISE16) && !pin_edge.rise
         |=> (st.presc == $past(st.presc));
   endproperty
   a_presc_keep: assert property (p_presc_keep)
      else $error("prescaler changed on a direct mode switch");

   property p_sleep_hold;
      @(posedge core_clk) disable iff (!rstn)
      sleep_mode && !st.tb_ext && !wr_tb
         |=> (st.tb_count == $past(st.tb_count));
   endproperty
   a_sleep_hold: assert property (p_sleep_hold)
      else $error("internal timebase counted during sleep");

   property p_sleep_ext;
      @(posedge core_clk) disable iff (!rstn)
      sleep_mode && st.tb_ext && st.tb_run && ext_edge.rise && !wr_tb
         |=> (st.tb_count == 16'($past(st.tb_count) + 16'h0001));
   endproperty
   a_sleep_ext: assert property (p_sleep_ext)
      else $error("external timebase stalled during sleep");

   property p_off_no_capture;
      @(posedge core_clk) disable iff (!rstn)
      (st.mode == `TCU_MODE_OFF) |-> !cap;
   endproperty
   a_off_no_capture: assert property (p_off_no_capture)
      else $error("capture made while the unit is off");

   property p_pin_latency;
      @(posedge core_clk) disable iff (!rstn)
      (st.mode == `TCU_MODE_RISE) && !wr_ctrl && $rose(capture_pin)
         ##1 (st.mode == `TCU_MODE_RISE) ##1 (st.mode == `TCU_MODE_RISE)
         |-> cap;
   endproperty
   a_pin_latency: assert property (p_pin_latency)
      else $error("rising pin edge not captured two cycles later");

   property p_read_result;
      @(posedge core_clk) disable iff (!rstn)
      bus.rd && (bus.addr == `TCU_OFS_RES_LO)
         |=> (rdata == $past(st.result[7:0]));
   endproperty
   a_read_result: assert property (p_read_result)
      else $error("result low byte read back wrong");

   property p_rise_event;
      @(posedge core_clk) disable iff (!rstn)
      (st.mode == `TCU_MODE_RISE) && pin_edge.rise |-> cap;
   endproperty
   a_rise_event: assert property (p_rise_event)
      else $error("rising edge not captured in rising mode");

   property p_sixteenth_edge;
      @(posedge core_clk) disable iff (!rstn)
      (st.mode == `TCU_MODE_RISE16) && pin_edge.rise &&
         (st.presc == `TCU_PRESC_16) |-> cap;
   endproperty
   a_sixteenth_edge: assert property (p_sixteenth_edge)
      else $error("sixteenth rising edge not captured");

   property p_flag_clear;
      @(posedge core_clk) disable iff (!rstn)
      wr_req && bus.wdata[`TCU_FLAG_BIT] && !cap |=> !st.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("software write of one did not clear the flag");

   property p_sleep_capture;
      @(posedge core_clk) disable iff (!rstn)
      sleep_mode && st.tb_ext && cap
         |=> st.flag && (st.result == $past(st.tb_count));
   endproperty
   a_sleep_capture: assert property (p_sleep_capture)
      else $error("capture in sleep did not latch or flag");

endmodule

// file: tcu_cfg.svh
`ifndef TCU_CFG_SVH
`define TCU_CFG_SVH

// Register port widths.
`define TCU_AW 4
`define TCU_DW 8

// Register offsets.
`define TCU_OFS_CTRL 4'h0
`define TCU_OFS_RES_LO 4'h1
`define TCU_OFS_RES_HI 4'h2
`define TCU_OFS_REQ 4'h3
`define TCU_OFS_ENA 4'h4
`define TCU_OFS_TB_CFG 4'h5
`define TCU_OFS_TB_LO 4'h6
`define TCU_OFS_TB_HI 4'h7

// Field positions.
`define TCU_MODE_LSB 0
`define TCU_MODE_MSB 3
`define TCU_FLAG_BIT 0
`define TCU_ENA_BIT 0
`define TCU_TB_RUN_BIT 0
`define TCU_TB_EXT_BIT 1

// Mode select codes.
`define TCU_MODE_OFF 4'h0
`define TCU_MODE_FALL 4'h4
`define TCU_MODE_RISE 4'h5
`define TCU_MODE_RISE4 4'h6
`define TCU_MODE_RISE16 4'h7

// Prescaler terminal counts.
`define TCU_PRESC_4 4'h3
`define TCU_PRESC_16 4'hf

// Reset values.
`define TCU_CTRL_RST 4'h0
`define TCU_RES_RST 16'h0000
`define TCU_TB_RST 16'h0000
`define TCU_PRESC_RST 4'h0
`define TCU_RDATA_RST 8'h00

// Timing: core clock period and instruction clock divide.
`define TCU_CLK_PERIOD_NS 20
`define TCU_INST_DIV 4
`define TCU_INST_LAST 2'h3

`endif

// file: tcu_edge_detect.sv
`timescale 1ns/1ps

module tcu_edge_detect (
   // Clock and reset.
   input wire logic core_clk,
   input wire logic rstn,
   // Raw level.
   input wire logic level_in,
   // Edge pulses.
   output tcu_pkg::tcu_edge_s edge_out
);
   import tcu_pkg::*;

   tcu_sync_s st;
   tcu_sync_s next_st;

   // Three flops: two sync stages, then the edge compare checks the second stage against prev.
   always_comb begin
      next_st = st;
      next_st.stage1 = level_in;
      next_st.stage2 = st.stage1;
      next_st.prev = st.stage2;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign edge_out.rise = st.stage2 & ~st.prev;
   assign edge_out.fall = ~st.stage2 & st.prev;

endmodule

// file: tcu_pin_src.sv
`timescale 1ns/1ps

module tcu_pin_src (
   // Clock.
   input wire logic core_clk,
   // Command.
   input wire logic start,
   input wire logic [4:0] count,
   input wire logic [3:0] half,
   // Pin drive.
   output logic pin,
   output logic busy
);
   logic [4:0] left = 5'h00;
   logic [3:0] cnt = 4'h0;

   initial begin
      pin = 1'b0;
      busy = 1'b0;
   end

   always @(posedge core_clk) begin
      if (start && !busy) begin
         busy <= 1'b1;
         pin <= 1'b1;
         cnt <= 4'h0;
         left <= count;
      end else if (busy) begin
         if (cnt == half - 4'h1) begin
            cnt <= 4'h0;
            pin <= !pin;
            if (pin) begin
               left <= left - 5'h01;
               if (left == 5'h01) begin
                  busy <= 1'b0;
               end
            end
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// file: tcu_pkg.sv
`include "tcu_cfg.svh"

package tcu_pkg;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [`TCU_AW-1:0] addr;
      logic [`TCU_DW-1:0] wdata;
   } tcu_bus_req_s;

   typedef struct packed {
      logic rise;
      logic fall;
   } tcu_edge_s;

   typedef struct packed {
      logic stage1;
      logic stage2;
      logic prev;
   } tcu_sync_s;

   typedef struct packed {
      logic [3:0] mode;
      logic [15:0] result;
      logic flag;
      logic enable;
      logic tb_run;
      logic tb_ext;
      logic [15:0] tb_count;
      logic [1:0] div;
      logic [3:0] presc;
      logic [`TCU_DW-1:0] rdata;
   } tcu_state_s;

endpackage

// file: timer_capture_unit_tb.sv
`timescale 1ns/1ps
`include "tcu_cfg.svh"

module timer_capture_unit_tb;
   import tcu_pkg::*;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   tcu_bus_req_s bus = '0;
   logic [7:0] rdata;
   logic pin, busy, start = 1'b0, ext = 1'b0, sleep = 1'b0, irq;
   logic [4:0] count = 5'h00;
   logic [3:0] half = 4'h2;
   logic [15:0] tbc, v;
   logic [7:0] d;
   int fails = 0, cmp_count = 0, cyc = 0;

   tcu_capture dut_u (.core_clk(core_clk), .rstn(rstn), .bus(bus),
      .rdata(rdata), .capture_pin(pin), .timebase_ext_clk(ext),
      .sleep_mode(sleep), .irq(irq), .timebase_count(tbc));
   tcu_pin_src src_u (.core_clk(core_clk), .start(start), .count(count),
      .half(half), .pin(pin), .busy(busy));

   initial begin
      forever #10 core_clk = !core_clk;
   end

   task automatic give_verdict();
      if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 6000) begin
         fails++;
         give_verdict();
      end
   end

   task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(logic [3:0] a, logic [7:0] dt);
      @(posedge core_clk);
      bus.wr <= 1'b1;
      bus.addr <= a;
      bus.wdata <= dt;
      @(posedge core_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(logic [3:0] a, output logic [7:0] dt);
      @(posedge core_clk);
      bus.rd <= 1'b1;
      bus.addr <= a;
      @(posedge core_clk);
      bus.rd <= 1'b0;
      #1 dt = rdata;
   endtask

   task automatic rd_res(output logic [15:0] r);
      rd(`TCU_OFS_RES_LO, r[7:0]);
      rd(`TCU_OFS_RES_HI, r[15:8]);
   endtask

   task automatic set_tb(logic [15:0] t);
      wr(`TCU_OFS_TB_CFG, 8'h00);
      wr(`TCU_OFS_TB_LO, t[7:0]);
      wr(`TCU_OFS_TB_HI, t[15:8]);
   endtask

   task automatic set_mode(logic [3:0] m);
      wr(`TCU_OFS_CTRL, 8'h00);
      wr(`TCU_OFS_CTRL, {4'h0, m});
      wr(`TCU_OFS_REQ, 8'h01);
   endtask

   task automatic pulse(logic [4:0] n, logic [3:0] h);
      int k;
      @(posedge core_clk);
      start <= 1'b1;
      count <= n;
      half <= h;
      @(posedge core_clk);
      start <= 1'b0;
      @(posedge core_clk);
      for (k = 0; k < 600 && busy === 1'b1; k++) @(posedge core_clk);
      repeat (6) @(posedge core_clk);
   endtask

   task automatic t_reset();
      rd(`TCU_OFS_CTRL, d);
      chk("ctrl", {8'h00, d}, 16'h0000);
      rd(`TCU_OFS_REQ, d);
      chk("flag", {8'h00, d}, 16'h0000);
      rd(4'hf, d);
      chk("unmapped", {8'h00, d}, 16'h0000);
   endtask

   task automatic t_rise();
      set_tb(16'h1234);
      set_mode(`TCU_MODE_RISE);
      pulse(5'h01, 4'h2);
      rd_res(v);
      chk("res", v, 16'h1234);
      rd(`TCU_OFS_REQ, d);
      chk("flag", {8'h00, d}, 16'h0001);
      chk("irq off", {15'h0000, irq}, 16'h0000);
      set_tb(16'h5a78);
      pulse(5'h01, 4'h8);
      rd_res(v);
      chk("overwrite", v, 16'h5a78);
      wr(`TCU_OFS_REQ, 8'h00);
      rd(`TCU_OFS_REQ, d);
      chk("flag kept", {8'h00, d}, 16'h0001);
      wr(`TCU_OFS_ENA, 8'h01);
      repeat (2) @(posedge core_clk);
      chk("irq on", {15'h0000, irq}, 16'h0001);
      wr(`TCU_OFS_REQ, 8'h01);
      repeat (2) @(posedge core_clk);
      chk("irq clr", {15'h0000, irq}, 16'h0000);
      wr(`TCU_OFS_ENA, 8'h00);
   endtask

   task automatic t_fall();
      set_tb(16'h0bcd);
      set_mode(`TCU_MODE_FALL);
      @(posedge core_clk);
      start <= 1'b1;
      count <= 5'h01;
      half <= 4'hf;
      @(posedge core_clk);
      start <= 1'b0;
      repeat (7) @(posedge core_clk);
      rd(`TCU_OFS_REQ, d);
      chk("no rise", {8'h00, d}, 16'h0000);
      pulse(5'h00, 4'hf);
      rd(`TCU_OFS_REQ, d);
      chk("fall", {8'h00, d}, 16'h0001);
      rd_res(v);
      chk("fall res", v, 16'h0bcd);
   endtask

   task automatic t_presc(logic [3:0] m, logic [4:0] n);
      set_mode(m);
      pulse(n - 5'h01, 4'h2);
      rd(`TCU_OFS_REQ, d);
      chk("early", {8'h00, d}, 16'h0000);
      pulse(5'h01, 4'h2);
      rd(`TCU_OFS_REQ, d);
      chk("nth", {8'h00, d}, 16'h0001);
   endtask

   task automatic t_clear();
      set_mode(`TCU_MODE_RISE4);
      pulse(5'h02, 4'h2);
      set_mode(`TCU_MODE_RISE4);
      pulse(5'h03, 4'h2);
      rd(`TCU_OFS_REQ, d);
      chk("presc clr", {8'h00, d}, 16'h0000);
      wr(`TCU_OFS_CTRL, {4'h0, `TCU_MODE_RISE16});
      pulse(5'h0c, 4'h2);
      rd(`TCU_OFS_REQ, d);
      chk("switch early", {8'h00, d}, 16'h0000);
      pulse(5'h01, 4'h2);
      rd(`TCU_OFS_REQ, d);
      chk("switch nth", {8'h00, d}, 16'h0001);
      set_mode(4'h2);
      pulse(5'h04, 4'h2);
      rd(`TCU_OFS_REQ, d);
      chk("not capture", {8'h00, d}, 16'h0000);
   endtask

   task automatic t_sleep();
      wr(`TCU_OFS_TB_CFG, 8'h01);
      sleep <= 1'b1;
      repeat (2) @(posedge core_clk);
      v = tbc;
      repeat (20) @(posedge core_clk);
      chk("frozen", tbc, v);
      sleep <= 1'b0;
      repeat (2) @(posedge core_clk);
      v = tbc;
      repeat (20) @(posedge core_clk);
      chk("resume", tbc, v + 16'h0005);
      set_tb(16'h0000);
      wr(`TCU_OFS_TB_CFG, 8'h03);
      set_mode(`TCU_MODE_RISE);
      sleep <= 1'b1;
      repeat (3) begin
         ext <= 1'b1;
         repeat (4) @(posedge core_clk);
         ext <= 1'b0;
         repeat (4) @(posedge core_clk);
      end
      chk("ext count", tbc, 16'h0003);
      pulse(5'h01, 4'h2);
      rd_res(v);
      chk("sleep res", v, 16'h0003);
      rd(`TCU_OFS_REQ, d);
      chk("sleep flag", {8'h00, d}, 16'h0001);
      sleep <= 1'b0;
   endtask

   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_rise();
      t_fall();
      t_presc(`TCU_MODE_RISE4, 5'h04);
      t_presc(`TCU_MODE_RISE16, 5'h10);
      t_clear();
      t_sleep();
      give_verdict();
   end
endmodule
